// ### logic/flash_host_pkg.sv
// Purpose: Constants for the host-side controller of a bytewide command-driven flash memory.
// Assumes: mclk at 10 MHz; the flash is reached over its parallel pins only.
// Notes:   Contract
package flash_host_pkg;

  localparam int CLK_HZ            = 10_000_000;
  localparam int ADDR_W            = 16;

  // Command codes
  localparam logic [7:0] CMD_READ     = 8'h00;
  localparam logic [7:0] CMD_IDENT    = 8'h90;
  localparam logic [7:0] CMD_ERASE    = 8'h20;
  localparam logic [7:0] CMD_ERASE_VF = 8'ha0;
  localparam logic [7:0] CMD_PROG     = 8'h40;
  localparam logic [7:0] CMD_PROG_VF  = 8'hc0;
  localparam logic [7:0] CMD_RESET    = 8'hff;
  localparam logic [7:0] ERASED_BYTE  = 8'hff;
  localparam logic [7:0] PRE_ERASE    = 8'h00;

  // Times in their own units and derived cycle counts
  localparam int ERASE_PULSE_US    = 10_000;
  localparam int PROG_PULSE_NS     = 10_000;
  localparam int READ_WAIT_NS      = 6_000;
  localparam int ERASE_PULSE_CYC   = (ERASE_PULSE_US * (CLK_HZ / 1_000_000));
  localparam int PROG_PULSE_CYC    = (PROG_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int READ_WAIT_CYC     = (READ_WAIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int ERASE_TRIES       = 1000;
  localparam int PROG_TRIES        = 25;

  // Bus cycle phase lengths in mclk cycles
  localparam int SETUP_CYC         = 1;
  localparam int STROBE_CYC        = 2;
  localparam int HOLD_CYC          = 1;
  localparam int ACCESS_CYC        = 3;

  typedef enum logic [2:0] {
    OP_READ,
    OP_IDENT,
    OP_PROGRAM,
    OP_ERASE_CHIP,
    OP_RESET
  } op_t;

  typedef enum logic [1:0] {
    ST_OK,
    ST_PROG_FAIL,
    ST_ERASE_FAIL,
    ST_NO_SUPPLY
  } status_t;

endpackage : flash_host_pkg

// ### logic/flash_bus_cycle.sv
// Purpose: One write or read cycle on the flash parallel pins.
// Assumes: Flash pins are driven directly; mclk 10 MHz.
// Notes:   On write cycles select and strobe fall and rise together, so both edges coincide.
module flash_bus_cycle
  import flash_host_pkg::*;
#(
  parameter int AW = ADDR_W
)
(
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic          start,
  input  wire logic          is_write,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic               done,
  output logic [7:0]         rdata_q,
  output logic [AW-1:0]      flash_addr_q,
  output logic               select_n_q,
  output logic               gate_n_q,
  output logic               strobe_n_q,
  output logic [7:0]         byte_bus_o_q,
  output logic               byte_bus_oe_q,
  input  wire logic [7:0]    byte_bus_i
);

  typedef enum logic [2:0] {
    BC_IDLE,
    BC_SETUP,
    BC_STROBE,
    BC_HOLD,
    BC_ACCESS
  } bc_state_t;

  bc_state_t state_q;
  logic [3:0] cnt_q;
  logic       wr_q;

  assign done = (state_q == BC_HOLD && cnt_q == 4'h0) || (state_q == BC_ACCESS && cnt_q == 4'h0);

  // =====================================================
  // Sequencing
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_q       <= BC_IDLE;
      cnt_q         <= 4'h0;
      wr_q          <= 1'b0;
      flash_addr_q  <= '0;
      select_n_q    <= 1'b1;
      gate_n_q      <= 1'b1;
      strobe_n_q    <= 1'b1;
      byte_bus_o_q  <= 8'h00;
      byte_bus_oe_q <= 1'b0;
      rdata_q       <= 8'h00;
    end
    else
    begin
      unique case (state_q)
        BC_IDLE:
        begin
          if (start)
          begin
            wr_q          <= is_write;
            flash_addr_q  <= addr;
            byte_bus_o_q  <= wdata;
            byte_bus_oe_q <= is_write;
            gate_n_q      <= is_write;
            cnt_q         <= 4'(SETUP_CYC - 1);
            state_q       <= BC_SETUP;
          end
        end
        BC_SETUP:
        begin
          if (cnt_q == 4'h0)
          begin
            select_n_q <= 1'b0;
            strobe_n_q <= ~wr_q;
            gate_n_q   <= wr_q;
            cnt_q      <= wr_q ? 4'(STROBE_CYC - 1) : 4'(ACCESS_CYC - 1);
            state_q    <= wr_q ? BC_STROBE : BC_ACCESS;
          end
          else
            cnt_q <= cnt_q - 4'h1;
        end
        BC_STROBE:
        begin
          if (cnt_q == 4'h0)
          begin
            strobe_n_q <= 1'b1;
            select_n_q <= 1'b1;
            cnt_q      <= 4'(HOLD_CYC - 1);
            state_q    <= BC_HOLD;
          end
          else
            cnt_q <= cnt_q - 4'h1;
        end
        BC_HOLD:
        begin
          if (cnt_q == 4'h0)
          begin
            byte_bus_oe_q <= 1'b0;
            gate_n_q      <= 1'b1;
            state_q       <= BC_IDLE;
          end
          else
            cnt_q <= cnt_q - 4'h1;
        end
        BC_ACCESS:
        begin
          // Sampled every access cycle, so done sees a settled byte; ACCESS_CYC must be 2 or more
          rdata_q <= byte_bus_i;
          if (cnt_q == 4'h0)
          begin
            select_n_q <= 1'b1;
            gate_n_q   <= 1'b1;
            state_q    <= BC_IDLE;
          end
          else
            cnt_q <= cnt_q - 4'h1;
        end
      endcase
    end
  end

  // =====================================================
  // Checks
  write_gate_a: assert property (@(posedge mclk) disable iff (rst)
    !strobe_n_q |-> (gate_n_q && !select_n_q && byte_bus_oe_q))
    else $error("strobe low without gate high and select low");

  read_drive_a: assert property (@(posedge mclk) disable iff (rst)
    !gate_n_q |-> (strobe_n_q && !byte_bus_oe_q))
    else $error("gate low while host drives or strobes");

  strobe_len_a: assert property (@(posedge mclk) disable iff (rst)
    $fell(strobe_n_q) |-> !strobe_n_q [*2] ##1 strobe_n_q)
    else $error("strobe width wrong");

endmodule : flash_bus_cycle

// ### logic/flash_host.sv
// Purpose: Host controller that reads, identifies, programs and bulk-erases the flash.
// Assumes: programming_supply_high switches the programming supply; caller holds req until ack.
// Notes:   Erase of the whole chip pre-programs every byte to zero first.
module flash_host
  import flash_host_pkg::*;
#(
  parameter int AW          = ADDR_W,
  parameter int ERASE_CYC   = ERASE_PULSE_CYC,
  parameter int LAST_ADDR   = (1 << ADDR_W) - 1
)
(
  input  wire logic          mclk,
  input  wire logic          rst,
  input  wire logic          req,
  input  wire op_t           op,
  input  wire logic [AW-1:0] req_addr,
  input  wire logic [7:0]    req_data,
  output logic               ack,
  output logic [7:0]         resp_data_q,
  output status_t            status_q,
  input  wire logic          supply_ready,
  output logic               programming_supply_high,
  output logic               identifier_high_voltage,
  output logic [AW-1:0]      flash_addr,
  output logic               select_n,
  output logic               gate_n,
  output logic               strobe_n,
  output logic [7:0]         byte_bus_o,
  output logic               byte_bus_oe,
  input  wire logic [7:0]    byte_bus_i
);

  typedef enum logic [3:0] {
    S_IDLE,
    S_CMD,
    S_CMD2,
    S_WAIT,
    S_READ,
    S_CHECK,
    S_DONE
  } st_t;

  st_t             state_q;
  op_t             op_q;
  logic [AW-1:0]   addr_q;
  logic [7:0]      data_q;
  logic [7:0]      cmd1_q;
  logic [7:0]      cmd2_q;
  logic            cmd2_wr_q;
  logic            read_next_q;
  logic            erase_pre_q;
  logic [23:0]     wait_q;
  logic [9:0]      tries_q;
  logic            ack_q;
  logic            bc_start;
  logic            bc_wr;
  logic [AW-1:0]   bc_addr;
  logic [7:0]      bc_wdata;
  logic            bc_done;
  logic [7:0]      bc_rdata;

  // =====================================================
  // Pin cycle engine
  flash_bus_cycle #(.AW(AW)) u_cycle (
    .mclk          (mclk),
    .rst           (rst),
    .start         (bc_start),
    .is_write      (bc_wr),
    .addr          (bc_addr),
    .wdata         (bc_wdata),
    .done          (bc_done),
    .rdata_q       (bc_rdata),
    .flash_addr_q  (flash_addr),
    .select_n_q    (select_n),
    .gate_n_q      (gate_n),
    .strobe_n_q    (strobe_n),
    .byte_bus_o_q  (byte_bus_o),
    .byte_bus_oe_q (byte_bus_oe),
    .byte_bus_i    (byte_bus_i)
  );

  logic cyc_busy_q;
  assign bc_start = (state_q == S_CMD || state_q == S_CMD2 || state_q == S_READ) && !cyc_busy_q;
  assign bc_wr    = (state_q != S_READ);
  assign bc_wdata = (state_q == S_CMD) ? cmd1_q : cmd2_q;
  assign bc_addr  = addr_q;
  assign ack      = ack_q;
  // Identifier bytes come through commands, so the high-voltage line is never raised here.
  assign identifier_high_voltage = 1'b0;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      cyc_busy_q <= 1'b0;
    else if (bc_start)
      cyc_busy_q <= 1'b1;
    else if (bc_done)
      cyc_busy_q <= 1'b0;
  end

  // =====================================================
  // Operation sequencer
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_q                 <= S_IDLE;
      op_q                    <= OP_READ;
      addr_q                  <= '0;
      data_q                  <= 8'h00;
      cmd1_q                  <= CMD_READ;
      cmd2_q                  <= CMD_READ;
      cmd2_wr_q               <= 1'b0;
      read_next_q             <= 1'b0;
      erase_pre_q             <= 1'b0;
      wait_q                  <= 24'h0;
      tries_q                 <= 10'h0;
      ack_q                   <= 1'b0;
      resp_data_q             <= 8'h00;
      status_q                <= ST_OK;
      programming_supply_high <= 1'b0;
    end
    else
    begin
      ack_q <= 1'b0;
      unique case (state_q)
        S_IDLE:
        begin
          if (req && !ack_q)
          begin
            op_q                    <= op;
            addr_q                  <= req_addr;
            data_q                  <= req_data;
            tries_q                 <= 10'h0;
            programming_supply_high <= 1'b1;
            erase_pre_q             <= (op == OP_ERASE_CHIP);
            if (op == OP_ERASE_CHIP)
              addr_q <= '0;
            state_q <= S_WAIT;
            wait_q  <= 24'h0;
            cmd2_wr_q <= 1'b0;
            cmd1_q  <= CMD_READ;
          end
        end
        S_WAIT:
        begin
          if (!supply_ready)
            wait_q <= wait_q;
          else if (wait_q != 24'h0)
            wait_q <= wait_q - 24'h1;
          else if (read_next_q)
            state_q <= S_READ;
          else if (cmd1_q == CMD_PROG_VF || cmd1_q == CMD_ERASE_VF)
            state_q <= S_CMD;
          else
          begin
            unique case (op_q)
              OP_READ:  begin cmd1_q <= CMD_READ;  cmd2_wr_q <= 1'b0; end
              OP_IDENT: begin cmd1_q <= CMD_IDENT; cmd2_wr_q <= 1'b0; end
              OP_RESET: begin cmd1_q <= CMD_RESET; cmd2_q <= CMD_RESET; cmd2_wr_q <= 1'b1; end
              OP_PROGRAM,
              OP_ERASE_CHIP:
              begin
                cmd1_q    <= erase_pre_q || op_q == OP_PROGRAM ? CMD_PROG : CMD_ERASE;
                cmd2_q    <= erase_pre_q ? PRE_ERASE : (op_q == OP_PROGRAM ? data_q : CMD_ERASE);
                cmd2_wr_q <= 1'b1;
              end
            endcase
            state_q <= S_CMD;
          end
        end
        S_CMD:
        begin
          if (bc_done)
            state_q <= cmd2_wr_q ? S_CMD2 : S_WAIT;
          if (bc_done)
            read_next_q <= !cmd2_wr_q;
          if (bc_done && !cmd2_wr_q)
            wait_q <= (cmd1_q == CMD_PROG_VF || cmd1_q == CMD_ERASE_VF) ? 24'h0 : 24'(READ_WAIT_CYC);
        end
        S_CMD2:
        begin
          if (bc_done)
          begin
            if (op_q == OP_RESET)
              state_q <= S_DONE;
            else
            begin
              // Pulse timing: erase for the long pulse, otherwise program pulse.
              wait_q <= (cmd1_q == CMD_ERASE) ? 24'(ERASE_CYC) : 24'(PROG_PULSE_CYC);
              cmd1_q <= (cmd1_q == CMD_ERASE) ? CMD_ERASE_VF : CMD_PROG_VF;
              cmd2_wr_q <= 1'b0;
              state_q <= S_WAIT;
            end
          end
        end
        S_READ:
        begin
          if (bc_done)
          begin
            resp_data_q <= bc_rdata;
            read_next_q <= 1'b0;
            state_q     <= (op_q == OP_READ || op_q == OP_IDENT) ? S_DONE : S_CHECK;
          end
        end
        S_CHECK:
        begin
          if (cmd1_q == CMD_PROG_VF)
          begin
            if (resp_data_q == cmd2_q)
            begin
              tries_q <= 10'h0;
              if (erase_pre_q && addr_q != AW'(LAST_ADDR))
              begin
                addr_q <= addr_q + 1'b1;
                cmd1_q <= CMD_READ;
                state_q <= S_WAIT;
              end
              else if (erase_pre_q)
              begin
                erase_pre_q <= 1'b0;
                addr_q  <= '0;
                cmd1_q  <= CMD_READ;
                state_q <= S_WAIT;
              end
              else
                state_q <= S_DONE;
            end
            else if (tries_q == 10'(PROG_TRIES - 1))
            begin
              status_q <= ST_PROG_FAIL;
              state_q  <= S_DONE;
            end
            else
            begin
              tries_q <= tries_q + 10'h1;
              cmd1_q  <= CMD_READ;
              state_q <= S_WAIT;
            end
          end
          else
          begin
            // Erase-verify: one cmd write with address then a read, per byte.
            if (resp_data_q == ERASED_BYTE && addr_q == AW'(LAST_ADDR))
              state_q <= S_DONE;
            else if (resp_data_q == ERASED_BYTE)
            begin
              addr_q  <= addr_q + 1'b1;
              cmd1_q  <= CMD_ERASE_VF;
              cmd2_wr_q <= 1'b0;
              state_q <= S_CMD;
            end
            else if (tries_q == 10'(ERASE_TRIES - 1))
            begin
              status_q <= ST_ERASE_FAIL;
              state_q  <= S_DONE;
            end
            else
            begin
              tries_q <= tries_q + 10'h1;
              cmd1_q  <= CMD_READ;
              state_q <= S_WAIT;
            end
          end
        end
        S_DONE:
        begin
          programming_supply_high <= 1'b0;
          ack_q   <= 1'b1;
          state_q <= S_IDLE;
        end
        default:
          state_q <= S_IDLE;
      endcase
      if (state_q == S_IDLE && req && !ack_q)
        status_q <= ST_OK;
    end
  end

  // =====================================================
  // Checks
  supply_cmd_a: assert property (@(posedge mclk) disable iff (rst)
    !strobe_n |-> programming_supply_high)
    else $error("command written without programming supply");
  prog_tries_a: assert property (@(posedge mclk) disable iff (rst)
    state_q == S_CHECK |-> tries_q < ((cmd1_q == CMD_PROG_VF) ? 10'(PROG_TRIES) : 10'(ERASE_TRIES)))
    else $error("retry count past limit");
  erase_wait_a: assert property (@(posedge mclk) disable iff (rst)
    (state_q == S_CMD2 && bc_done && cmd1_q == CMD_ERASE) |=> wait_q == 24'(ERASE_CYC))
    else $error("erase pulse time not loaded");
  prog_wait_a: assert property (@(posedge mclk) disable iff (rst)
    (state_q == S_CMD2 && bc_done && cmd1_q == CMD_PROG) |=> wait_q == 24'(PROG_PULSE_CYC))
    else $error("program pulse time not loaded");
  read_wait_a: assert property (@(posedge mclk) disable iff (rst)
    (state_q == S_CMD && bc_done && !cmd2_wr_q && cmd1_q == CMD_READ) |=> wait_q == 24'(READ_WAIT_CYC))
    else $error("read settle wait not loaded");

endmodule : flash_host

// ### tb/flash_dev_model.sv
// Purpose: Behavioural bytewide flash device, four bytes deep, for the host bench.
// Assumes: Pins are sampled on their own edges; there is no clock.
// Notes:   Host misbehaviour is counted in breaks; the fail counters inject bad verifies.
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter int         ERASE_NS = 2000,
  parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] PART_ID  = 8'h3c  // Arbitrary value
)
(
  input  wire logic        supply,
  input  wire logic        id_volt,
  input  wire logic [15:0] addr,
  input  wire logic        select_n,
  input  wire logic        gate_n,
  input  wire logic        strobe_n,
  input  wire logic [7:0]  din,
  input  wire logic        host_oe,
  output logic [7:0]       dout,
  output int               breaks
);
  // ==========================================================
  // State
  logic [7:0] mem [4];
  logic [7:0] val, park, pend, pd, ev;
  logic [1:0] la, pa;
  logic       drive, erasing, wr_on;
  int         mode, ev_next, prog_fail_left, erase_fail_left;
  realtime    t_er, t_pg, t_rd;

  initial
  begin
    foreach (mem[i]) mem[i] = 8'hff;
    {mode, ev_next, breaks, prog_fail_left, erase_fail_left} = '0;
    {pend, pd, ev, pa, la, erasing, park} = '0;
    t_er = 0.0;
    t_pg = 0.0;
    t_rd = 0.0;
  end

  // ==========================================================
  // Command writes
  assign wr_on = !select_n && !strobe_n && gate_n && supply;
  always @(posedge wr_on) la = addr[1:0];
  // Supply edges fall back to reading so no stale command survives a ramp
  always @(supply)
  begin
    mode = 0;
    pend = 8'h01;
  end
  always @(negedge wr_on)
  begin : exec_blk
    logic nz;
    nz = 1'b0;
    if (supply === 1'b1)
    begin
      if (pend == CMD_PROG)
      begin
        pa = la;
        pd = din;
        t_pg = $realtime;
        pend = 8'h01;
      end
      else if (pend == CMD_ERASE && din == CMD_ERASE)
      begin
        foreach (mem[i]) nz |= (mem[i] != 8'h00);
        if (nz) breaks++;
        erasing = 1'b1;
        t_er = $realtime;
        pend = 8'h01;
      end
      else if (pend == CMD_RESET && din == CMD_RESET)
      begin
        mode = 0;
        pend = 8'h01;
      end
      else
      begin
        pend = din;
        case (din)
          CMD_READ:
          begin
            mode = 0;
            t_rd = $realtime;
          end
          8'h80, CMD_IDENT: mode = 1;
          CMD_PROG: ev_next = 0;
          CMD_ERASE_VF:
          begin
            if (erasing && $realtime - t_er < ERASE_NS) breaks++;
            if (la != ev_next[1:0]) breaks++;
            if (erasing && erase_fail_left > 0) erase_fail_left--;
            else if (erasing) foreach (mem[i]) mem[i] = 8'hff;
            erasing = 1'b0;
            mode = 2;
            ev = mem[la];
            if (ev == ERASED_BYTE) ev_next++;
          end
          CMD_PROG_VF:
          begin
            if ($realtime - t_pg < 10_000) breaks++;
            if (prog_fail_left > 0) prog_fail_left--;
            else mem[pa] = mem[pa] & pd;
            mode = 3;
          end
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // Read path
  always_comb
  begin
    case (mode)
      1: val = addr[0] ? PART_ID : MAKER_ID;
      2: val = ev;
      3: val = mem[pa];
      default: val = mem[addr[1:0]];
    endcase
    if (id_volt && !supply) val = addr[0] ? PART_ID : MAKER_ID;
  end
  assign drive = !select_n && !gate_n && strobe_n;
  // Released bus shows the inverse, so a host that samples late gets caught
  always @(val or drive) if (drive) park = ~val;
  assign dout = drive ? val : park;
  always @(posedge drive) if (mode == 0 && $realtime - t_rd < 6000) breaks++;
  always @(drive or host_oe) if (drive && host_oe) breaks++;
endmodule : flash_dev_model

// ### tb/flash_host_tb_top.sv
// Purpose: Self-checking bench for the flash host controller.
// Assumes: Erase pulse cut to 20 cycles and the erase walk to four bytes.
// Notes:   Expected results queue at the driver; a monitor pops one per ack.
module flash_host_tb_top
  import flash_host_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct { logic [7:0] data; status_t st; logic chk; } note_t;
  localparam int         ERASE_C = 20;
  localparam logic [7:0] MAKER   = 8'h5a;
  localparam logic [7:0] PART    = 8'h3c;
  logic        mclk, rst, req, ack, supply_ready, psh, idv, sel_n, gate_n, str_n, oe;
  op_t         op;
  status_t     status;
  logic [15:0] req_addr, faddr;
  logic [7:0]  req_data, resp, bo, bi, md, d;
  logic [7:0]  shadow [4];
  note_t       notes [$];
  note_t       cur;
  int          n_errors, n_tests, ramp, i, breaks;
  integer      seed = 32'hbe24f7f7;

  flash_host #(.ERASE_CYC(ERASE_C), .LAST_ADDR(3)) DUT (
    .mclk(mclk), .rst(rst), .req(req), .op(op), .req_addr(req_addr), .req_data(req_data),
    .ack(ack), .resp_data_q(resp), .status_q(status), .supply_ready(supply_ready),
    .programming_supply_high(psh), .identifier_high_voltage(idv), .flash_addr(faddr),
    .select_n(sel_n), .gate_n(gate_n), .strobe_n(str_n), .byte_bus_o(bo),
    .byte_bus_oe(oe), .byte_bus_i(bi));
  flash_dev_model #(.ERASE_NS(ERASE_C * 100), .MAKER_ID(MAKER), .PART_ID(PART)) dev (
    .supply(supply_ready), .id_volt(idv), .addr(faddr), .select_n(sel_n), .gate_n(gate_n),
    .strobe_n(str_n), .din(bo), .host_oe(oe), .dout(md), .breaks(breaks));
  assign bi = oe ? bo : md;

  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ==========================================================
  // Supply ramp, a few cycles behind the switch
  always @(negedge mclk)
  begin
    ramp <= psh ? ((ramp < 3) ? ramp + 1 : ramp) : 0;
    supply_ready <= psh && ramp == 3;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  task automatic do_op(input op_t o, input int a, input logic [7:0] dat, input note_t n);
    int k;
    notes.push_back(n);
    req = 1'b1;
    op = o;
    req_addr = 16'(a);
    req_data = dat;
    for (k = 0; k < 80000 && ack !== 1'b1; k++) @(negedge mclk);
    if (k == 80000)
    begin
      n_errors++;
      report_and_stop();
    end
    req = 1'b0;
    @(negedge mclk);
  endtask : do_op

  // ==========================================================
  // Monitor
  always @(negedge mclk)
    if (ack === 1'b1)
    begin
      if (notes.size() == 0)
        check(1, 0);
      else
      begin
        cur = notes.pop_front();
        check(status, cur.st);
        if (cur.chk) check(resp, cur.data);
      end
    end

  // ==========================================================
  // Scenarios
  initial
  begin
    rst = 1'b1;
    req = 1'b0;
    op = OP_READ;
    req_addr = '0;
    req_data = '0;
    supply_ready = 1'b0;
    ramp = 0;
    n_errors = 0;
    n_tests = 0;
    repeat (6) @(negedge mclk);
    check({sel_n, gate_n, str_n, oe, psh}, 5'b11100);
    rst = 1'b0;
    @(negedge mclk);
    for (i = 0; i < 4; i++)
    begin
      shadow[i] = 8'($random(seed));
      do_op(OP_PROGRAM, i, shadow[i], '{shadow[i], ST_OK, 1'b1});
    end
    for (i = 0; i < 4; i++)
      do_op(OP_READ, i, 8'h00, '{shadow[i], ST_OK, 1'b1});
    do_op(OP_IDENT, 0, 8'h00, '{MAKER, ST_OK, 1'b1});
    do_op(OP_IDENT, 1, 8'h00, '{PART, ST_OK, 1'b1});
    do_op(OP_RESET, 0, 8'h00, '{8'h00, ST_OK, 1'b0});
    dev.prog_fail_left = 24;
    d = shadow[0] & 8'($random(seed));
    shadow[0] = shadow[0] & d;
    do_op(OP_PROGRAM, 0, d, '{shadow[0], ST_OK, 1'b1});
    dev.prog_fail_left = 25;
    do_op(OP_PROGRAM, 1, 8'h00, '{8'h00, ST_PROG_FAIL, 1'b0});
    do_op(OP_READ, 1, 8'h00, '{shadow[1], ST_OK, 1'b1});
    dev.erase_fail_left = 2;
    do_op(OP_ERASE_CHIP, 0, 8'h00, '{ERASED_BYTE, ST_OK, 1'b1});
    for (i = 0; i < 4; i++)
      do_op(OP_READ, i, 8'h00, '{ERASED_BYTE, ST_OK, 1'b1});
    dev.erase_fail_left = 1000;
    do_op(OP_ERASE_CHIP, 0, 8'h00, '{8'h00, ST_ERASE_FAIL, 1'b0});
    do_op(OP_READ, 2, 8'h00, '{PRE_ERASE, ST_OK, 1'b1});
    check(breaks, 0);
    check(notes.size(), 0);
    report_and_stop();
  end
endmodule : flash_host_tb_top
